// >>> hdl/audio_rx_consts.svh
`ifndef AUDIO_RX_CONSTS_SVH
`define AUDIO_RX_CONSTS_SVH

// Status and control register
`define RX_SCR_RESET       16'h0004
`define RX_SCR_WR_MASK     16'hfff0
`define RX_AF_BIT          0
`define RX_FULL_BIT        1
`define RX_EMPTY_BIT       2
`define RX_OVF_BIT         3
`define RX_SA_LSB          4
`define RX_DSA_LSB         8
`define RX_FWL_LSB         12

// Receive FIFO and frame geometry
`define RX_FIFO_DEPTH      16
`define RX_FIFO_AW         4
`define RX_WORD_BITS       16
`define RX_SLOT_MAX        4
`define RX_BIT_LAST        4'h0f
`define RX_DMA_REQ_SLOTS   2

`endif

// >>> hdl/audio_rx_pkg.sv
package audio_rx_pkg;

	typedef logic [15:0] rx_word_t;

	// Status and control register layout, msb first
	typedef struct packed {
		logic [3:0] rx_fifo_warn_level;
		logic [3:0] rx_dma_slot_assign;
		logic [3:0] rx_slot_assign;
		logic       rx_overflow_flag;
		logic       rx_fifo_empty_flag;
		logic       rx_fifo_full_flag;
		logic       rx_almost_full_flag;
	} rx_scr_t;

	// Serial link pins after synchronisation
	typedef struct packed {
		logic bit_clk;
		logic frame_sync;
		logic data;
	} rx_link_t;

	typedef enum logic {
		frame_idle,
		frame_run
	} rx_frame_state_t;

endpackage

// >>> hdl/rx_two_entry_buffer.sv
`timescale 1ns/1ps
`default_nettype none

module rx_two_entry_buffer (
	// Clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   rstn,
	// Filling side
	input  wire logic                   in_valid,
	output logic                        in_ready,
	input  wire audio_rx_pkg::rx_word_t in_data,
	// Draining side
	output logic                        out_valid,
	input  wire logic                   out_ready,
	output audio_rx_pkg::rx_word_t      out_data
);
	import audio_rx_pkg::*;

	rx_word_t head_r;
	rx_word_t tail_r;
	logic     head_v_r;
	logic     tail_v_r;
	logic     push;
	logic     pop;

	assign in_ready  = ~tail_v_r;
	assign out_valid = head_v_r;
	assign out_data  = head_r;
	assign push      = in_valid & ~tail_v_r;
	assign pop       = head_v_r & out_ready;

	// Head is the output register; tail only fills while head stalls
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			head_r   <= 16'h0000;
			tail_r   <= 16'h0000;
			head_v_r <= 1'b0;
			tail_v_r <= 1'b0;
		end else if (pop) begin
			if (tail_v_r) begin
				head_r   <= tail_r;
				tail_v_r <= 1'b0;
			end else if (push) begin
				head_r <= in_data;
			end else begin
				head_v_r <= 1'b0;
			end
		end else if (push) begin
			if (!head_v_r) begin
				head_r   <= in_data;
				head_v_r <= 1'b1;
			end else begin
				tail_r   <= in_data;
				tail_v_r <= 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// >>> hdl/audio_receive_path_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "audio_rx_consts.svh"

// Overview of operation
// - Writing one clears transmit error pending
// - Overrun error interrupt only when enabled
// - Status register resets to 0004h
// - Almost full when count equals limit
// - Full: pointers equal, last access write
// - Empty: pointers equal, last access read
// - Overflow sets flag, drops word, pointer held
// - Dropped word raises no receive interrupt or DMA
// - Slot assign bit n enables slot n
// - Slot bits beyond frame length ignored
// - DMA slot routes word to slot register
// - DMA request when register full and enabled
// - DMA slot bit ignored for unassigned slot
// - Receive interrupt when count exceeds level
// - Level zero: interrupt on any entry
// - Receive interrupt needs its enable bit
// - Master DMA field serves slots 0 and 1
module audio_receive_path_control (
	// Clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   rstn,
	// Serial link pins from the codec
	input  wire logic                   link_bit_clk,
	input  wire logic                   link_frame_sync,
	input  wire logic                   link_data,
	// Frame geometry: slots per frame minus one
	input  wire logic [1:0]             frame_slots_m1,
	// Status and control register access
	input  wire logic                   scr_wr,
	input  wire logic [15:0]            scr_wdata,
	output logic [15:0]                 scr_rdata,
	// Receive data port
	output logic                        rx_data_valid,
	input  wire logic                   rx_data_ready,
	output audio_rx_pkg::rx_word_t      rx_data,
	// Per-slot DMA data registers
	input  wire logic [3:0]             dma_rd,
	output audio_rx_pkg::rx_word_t      dma_data [4],
	output logic [3:0]                  dma_full,
	// DMA request control
	input  wire logic [3:0]             rx_master_dma_field,
	output logic [1:0]                  dma_req,
	// Interrupt control bits
	input  wire logic                   rx_irq_enable,
	input  wire logic                   rx_error_irq_enable,
	input  wire logic                   rx_error_irq_clear,
	input  wire logic                   tx_error_event,
	input  wire logic                   tx_error_irq_clear,
	output logic                        rx_irq,
	output logic                        rx_error_irq,
	output logic                        tx_error_pending
);
	import audio_rx_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Link synchronisers and edge detection
	rx_link_t        link_meta_r;
	rx_link_t        link_sync_r;
	logic            bit_clk_prev_r;
	logic            bit_clk_rise;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			link_meta_r    <= '0;
			link_sync_r    <= '0;
			bit_clk_prev_r <= 1'b0;
		end else begin
			link_meta_r    <= '{link_bit_clk, link_frame_sync, link_data};
			link_sync_r    <= link_meta_r;
			bit_clk_prev_r <= link_sync_r.bit_clk;
		end
	end

	assign bit_clk_rise = link_sync_r.bit_clk & ~bit_clk_prev_r;

	rx_scr_t         scr_ctl_r;
	logic            overflow_r;
	logic            rx_error_pending_r;
	logic            tx_error_pending_r;

	////////////////////////////////////////////////////////////////////////////
	// Receive shift register and slot tracking
	rx_frame_state_t frame_state_r;
	logic [3:0]      bit_cnt_r;
	logic [1:0]      slot_r;
	rx_word_t        rx_shift_register_r;
	rx_word_t        shift_nxt;
	logic            word_done;
	logic            slot_active;
	logic            slot_to_dma;

	assign shift_nxt = {rx_shift_register_r[14:0], link_sync_r.data};
	assign word_done = bit_clk_rise & (bit_cnt_r == `RX_BIT_LAST)
		& ((frame_state_r == frame_run) | link_sync_r.frame_sync);
	// Slots past the frame end never count as assigned
	assign slot_active = scr_ctl_r.rx_slot_assign[slot_r]
		& (slot_r <= frame_slots_m1);
	// An unassigned slot cannot be steered to DMA
	assign slot_to_dma = slot_active & scr_ctl_r.rx_dma_slot_assign[slot_r];

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			frame_state_r       <= frame_idle;
			bit_cnt_r           <= 4'h0;
			slot_r              <= 2'b00;
			rx_shift_register_r <= 16'h0000;
		end else if (bit_clk_rise) begin
			case (frame_state_r)
				frame_idle: begin
					if (link_sync_r.frame_sync) begin
						frame_state_r       <= frame_run;
						bit_cnt_r           <= 4'h1;
						slot_r              <= 2'b00;
						rx_shift_register_r <= shift_nxt;
					end
				end
				frame_run: begin
					rx_shift_register_r <= shift_nxt;
					if (link_sync_r.frame_sync) begin
						bit_cnt_r <= 4'h1;
						slot_r    <= 2'b00;
					end else begin
						bit_cnt_r <= bit_cnt_r + 4'h1;
						if (bit_cnt_r == `RX_BIT_LAST) begin
							if (slot_r == frame_slots_m1) begin
								frame_state_r <= frame_idle;
							end
							slot_r <= slot_r + 2'b01;
						end
					end
				end
				default: frame_state_r <= frame_idle;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive FIFO
	rx_word_t        fifo_mem [`RX_FIFO_DEPTH];
	logic [3:0]      rx_fifo_write_ptr_r;
	logic [3:0]      rx_fifo_read_ptr_r;
	logic            last_was_write_r;
	logic            fifo_full;
	logic            fifo_empty;
	logic [4:0]      fifo_count;
	logic            fifo_push;
	logic            fifo_pop;
	logic            fifo_drop;
	logic            buf_in_ready;

	assign fifo_full  = (rx_fifo_write_ptr_r == rx_fifo_read_ptr_r)
		& last_was_write_r;
	assign fifo_empty = (rx_fifo_write_ptr_r == rx_fifo_read_ptr_r)
		& ~last_was_write_r;
	assign fifo_count = fifo_full ? 5'h10 : {1'b0, rx_fifo_write_ptr_r - rx_fifo_read_ptr_r};
	assign fifo_push  = word_done & slot_active & ~slot_to_dma & ~fifo_full;
	assign fifo_drop  = word_done & slot_active & ~slot_to_dma & fifo_full;
	assign fifo_pop   = ~fifo_empty & buf_in_ready;

	// Pointer held on a dropped word
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rx_fifo_write_ptr_r <= 4'h0;
		end else if (fifo_push) begin
			rx_fifo_write_ptr_r <= rx_fifo_write_ptr_r + 4'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (fifo_push) begin
			fifo_mem[rx_fifo_write_ptr_r] <= shift_nxt;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rx_fifo_read_ptr_r <= 4'h0;
		end else if (fifo_pop) begin
			rx_fifo_read_ptr_r <= rx_fifo_read_ptr_r + 4'h1;
		end
	end

	// Simultaneous push and pop keeps the pointer gap, so the flag stays
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			last_was_write_r <= 1'b0;
		end else if (fifo_push & ~fifo_pop) begin
			last_was_write_r <= 1'b1;
		end else if (fifo_pop & ~fifo_push) begin
			last_was_write_r <= 1'b0;
		end
	end

	// Two entries between FIFO and reader so a stalled reader loses nothing
	rx_two_entry_buffer u_out_buf (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.in_valid  (~fifo_empty),
		.in_ready  (buf_in_ready),
		.in_data   (fifo_mem[rx_fifo_read_ptr_r]),
		.out_valid (rx_data_valid),
		.out_ready (rx_data_ready),
		.out_data  (rx_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// Per-slot DMA data registers
	rx_word_t        dma_data_r [4];
	logic [3:0]      dma_full_r;
	logic [1:0]      dma_req_r;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < `RX_SLOT_MAX; i++) begin
				dma_data_r[i] <= 16'h0000;
			end
			dma_full_r <= 4'h0;
		end else begin
			for (int i = 0; i < `RX_SLOT_MAX; i++) begin
				// A new word wins over a read in the same cycle
				if (word_done & slot_to_dma & (slot_r == i[1:0])) begin
					dma_data_r[i] <= shift_nxt;
					dma_full_r[i] <= 1'b1;
				end else if (dma_rd[i]) begin
					dma_full_r[i] <= 1'b0;
				end
			end
		end
	end

	// Only the two low slots can request; upper field bits unsupported
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			dma_req_r <= 2'b00;
		end else begin
			dma_req_r <= dma_full_r[1:0] & rx_master_dma_field[1:0];
		end
	end

	assign dma_data = dma_data_r;
	assign dma_full = dma_full_r;
	assign dma_req  = dma_req_r;

	////////////////////////////////////////////////////////////////////////////
	// Status and control register
	// Flag bits are never taken from the write data
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			scr_ctl_r <= `RX_SCR_RESET & `RX_SCR_WR_MASK;
		end else if (scr_wr) begin
			scr_ctl_r <= scr_wdata & `RX_SCR_WR_MASK;
		end
	end

	// Overflow is sticky until the error clear; a new overrun wins
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			overflow_r <= 1'b0;
		end else if (fifo_drop) begin
			overflow_r <= 1'b1;
		end else if (rx_error_irq_clear) begin
			overflow_r <= 1'b0;
		end
	end

	logic [15:0]     scr_rdata_r;
	rx_scr_t         scr_view;

	always_comb begin
		scr_view                     = scr_ctl_r;
		scr_view.rx_almost_full_flag = (fifo_count
			== {1'b0, scr_ctl_r.rx_fifo_warn_level});
		scr_view.rx_fifo_full_flag   = fifo_full;
		scr_view.rx_fifo_empty_flag  = fifo_empty;
		scr_view.rx_overflow_flag    = overflow_r;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			scr_rdata_r <= `RX_SCR_RESET;
		end else begin
			scr_rdata_r <= scr_view;
		end
	end

	assign scr_rdata = scr_rdata_r;

	////////////////////////////////////////////////////////////////////////////
	// Interrupts
	logic            rx_irq_r;

	// Level from the fill count; a dropped word never changes the count
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rx_irq_r <= 1'b0;
		end else begin
			rx_irq_r <= rx_irq_enable
				& (fifo_count > {1'b0, scr_ctl_r.rx_fifo_warn_level});
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rx_error_pending_r <= 1'b0;
		end else if (fifo_drop & rx_error_irq_enable) begin
			rx_error_pending_r <= 1'b1;
		end else if (rx_error_irq_clear) begin
			rx_error_pending_r <= 1'b0;
		end
	end

	// Clear input at zero leaves the flag alone; an event wins over a clear
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tx_error_pending_r <= 1'b0;
		end else if (tx_error_event) begin
			tx_error_pending_r <= 1'b1;
		end else if (tx_error_irq_clear) begin
			tx_error_pending_r <= 1'b0;
		end
	end

	assign rx_irq           = rx_irq_r;
	assign rx_error_irq     = rx_error_pending_r;
	assign tx_error_pending = tx_error_pending_r;

endmodule

`default_nettype wire

// >>> verification/audio_rx_props.sv
`timescale 1ns/1ps
`default_nettype none

module audio_rx_props (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rstn,
	// Register view
	input wire logic        scr_wr,
	input wire logic [15:0] scr_wdata,
	input wire logic [15:0] scr_rdata,
	// DMA
	input wire logic [3:0]  dma_full,
	input wire logic [3:0]  rx_master_dma_field,
	input wire logic [1:0]  dma_req,
	// Interrupts
	input wire logic        rx_irq_enable,
	input wire logic        rx_irq,
	input wire logic        rx_error_irq_enable,
	input wire logic        rx_error_irq,
	input wire logic        tx_error_event,
	input wire logic        tx_error_irq_clear,
	input wire logic        tx_error_pending
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	a_reset_value: assert property (!$past(rstn) |-> scr_rdata == 16'h0004)
		else $error("status register wrong after reset");
	a_tx_clear: assert property (tx_error_irq_clear && !tx_error_event |=> !tx_error_pending)
		else $error("transmit error pending not cleared");
	a_tx_hold: assert property (tx_error_pending && !tx_error_irq_clear |=> tx_error_pending)
		else $error("transmit error pending lost without clear");
	a_err_enable: assert property ($rose(rx_error_irq) |-> $past(rx_error_irq_enable))
		else $error("receive error interrupt while disabled");
	a_irq_enable: assert property (rx_irq |-> $past(rx_irq_enable))
		else $error("receive interrupt while disabled");
	a_full_empty: assert property (!(scr_rdata[1] && scr_rdata[2]))
		else $error("full and empty together");
	a_dma_req: assert property (dma_req == ($past(dma_full[1:0]) & $past(rx_master_dma_field[1:0])))
		else $error("dma request does not follow full and field");
	a_ctrl_store: assert property (scr_wr |-> ##2 scr_rdata[15:4] == $past(scr_wdata[15:4], 2))
		else $error("control bits not stored");
	a_dma_route: assert property ($rose(dma_full[0]) |-> scr_rdata[4] && scr_rdata[8])
		else $error("slot register filled without assignment");
	// First cycle after release still shows the reset value, so skip it
	a_af_empty: assert property ($past(rstn) && scr_rdata[2] && ~|scr_rdata[15:12]
		|-> scr_rdata[0]) else $error("almost full clear at empty with level zero");
	a_ovf_full: assert property ($rose(scr_rdata[3]) |-> $past(scr_rdata[1]))
		else $error("overflow set while not full");

	c_irq: cover property ($rose(rx_irq));
	c_dma: cover property (dma_req != 2'b00);
	c_ovf: cover property ($rose(scr_rdata[3]));
	c_err: cover property ($rose(rx_error_irq));
endmodule

bind audio_receive_path_control audio_rx_props audio_rx_props_i (
	.clk_sys, .rstn, .scr_wr, .scr_wdata, .scr_rdata, .dma_full, .rx_master_dma_field,
	.dma_req, .rx_irq_enable, .rx_irq, .rx_error_irq_enable, .rx_error_irq,
	.tx_error_event, .tx_error_irq_clear, .tx_error_pending
);

`default_nettype wire

// >>> verification/audio_codec_model.sv
`timescale 1ns/1ps
`default_nettype none

module audio_codec_model (
	// Serial link toward the receiver
	output logic bit_clk,
	output logic frame_sync,
	output logic data
);
	// Clock stands still between frames
	initial begin
		bit_clk = 1'b0;
		frame_sync = 1'b0;
		data = 1'b1;
	end

	// Msb first; data moves on the fall, far from the sampling rise
	task automatic send_frame(input logic [63:0] words, input int n);
		for (int i = 0; i < n * 16; i++) begin
			data = words[63 - i];
			frame_sync = (i == 0);
			#24 bit_clk = 1'b1;
			#24 bit_clk = 1'b0;
		end
		frame_sync = 1'b0;
		// No pull on the line, so show the inverse once released
		data = ~data;
	endtask
endmodule

`default_nettype wire

// >>> verification/audio_receive_path_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module audio_receive_path_control_tb;
	import audio_rx_pkg::*;

	logic       clk_sys = 1'b0;
	logic       rstn = 1'b0;
	logic       link_bit_clk;
	logic       link_frame_sync;
	logic       link_data;
	logic [1:0] frame_slots_m1 = 2'h3;
	logic       scr_wr = 1'b0;
	logic [15:0] scr_wdata = 16'h0000;
	logic [15:0] scr_rdata;
	logic       rx_data_valid;
	logic       rx_data_ready = 1'b0;
	rx_word_t   rx_data;
	logic [3:0] dma_rd = 4'h0;
	rx_word_t   dma_data [4];
	logic [3:0] dma_full;
	logic [3:0] rx_master_dma_field = 4'h0;
	logic [1:0] dma_req;
	logic       rx_irq_enable = 1'b0;
	logic       rx_error_irq_enable = 1'b0;
	logic       rx_error_irq_clear = 1'b0;
	logic       tx_error_event = 1'b0;
	logic       tx_error_irq_clear = 1'b0;
	logic       rx_irq;
	logic       rx_error_irq;
	logic       tx_error_pending;
	int         n_mismatch = 0;
	int         total_checks = 0;
	int         cyc = 0;

	always #2 clk_sys = ~clk_sys;

	audio_codec_model audio_codec_model_i (
		.bit_clk(link_bit_clk), .frame_sync(link_frame_sync), .data(link_data)
	);

	audio_receive_path_control audio_receive_path_control_i (
		.clk_sys, .rstn, .link_bit_clk, .link_frame_sync, .link_data, .frame_slots_m1,
		.scr_wr, .scr_wdata, .scr_rdata, .rx_data_valid, .rx_data_ready, .rx_data,
		.dma_rd, .dma_data, .dma_full, .rx_master_dma_field, .dma_req, .rx_irq_enable,
		.rx_error_irq_enable, .rx_error_irq_clear, .tx_error_event, .tx_error_irq_clear,
		.rx_irq, .rx_error_irq, .tx_error_pending
	);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] w(input int k);
		return 16'ha000 + 16'(k);
	endfunction

	task automatic stop_test;
		if (n_mismatch == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] v);
		scr_wr = 1'b1;
		scr_wdata = v;
		tick(1);
		scr_wr = 1'b0;
		tick(2);
	endtask

	// Reader stalls between words so the buffer is exercised
	task automatic rd(input int k);
		for (int t = 0; t < 8 && rx_data_valid !== 1'b1; t++)
			tick(1);
		chk(rx_data, w(k));
		rx_data_ready = 1'b1;
		tick(1);
		rx_data_ready = 1'b0;
		tick(1);
	endtask

	task automatic frm(input int b, input int n);
		audio_codec_model_i.send_frame({w(b), w(b + 1), w(b + 2), w(b + 3)}, n);
		tick(8);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Held for 16 cycles; after release the empty FIFO meets level zero
	task automatic t_reset;
		rstn = 1'b0;
		tick(16);
		chk(scr_rdata, 16'h0004);
		chk(16'({rx_irq, rx_error_irq, tx_error_pending, dma_req}), 16'h0000);
		chk(16'({dma_full, rx_data_valid}), 16'h0000);
		rstn = 1'b1;
		tick(1);
		chk(scr_rdata, 16'h0005);
	endtask

	task automatic t_tx;
		tx_error_event = 1'b1;
		tick(1);
		tx_error_event = 1'b0;
		tick(3);
		chk(16'(tx_error_pending), 16'h0001);
		tx_error_irq_clear = 1'b1;
		tick(1);
		tx_error_irq_clear = 1'b0;
		tick(1);
		chk(16'(tx_error_pending), 16'h0000);
	endtask

	task automatic t_slots;
		frm(50, 4);
		chk(16'(rx_data_valid), 16'h0000);
		frame_slots_m1 = 2'h1;
		wr(16'h00f0);
		frm(0, 4);
		rd(0);
		rd(1);
		chk(16'(rx_data_valid), 16'h0000);
		frame_slots_m1 = 2'h3;
		wr(16'h00a0);
		frm(10, 4);
		rd(11);
		rd(13);
		chk(16'(rx_data_valid), 16'h0000);
	endtask

	// Two words sit in the buffer, the rest count in the FIFO
	task automatic t_fill;
		wr(16'h20f0);
		frm(20, 4);
		chk(scr_rdata, 16'h20f1);
		chk(16'(rx_irq), 16'h0000);
		wr(16'h10f0);
		chk(scr_rdata, 16'h10f0);
		chk(16'(rx_irq), 16'h0000);
		rx_irq_enable = 1'b1;
		tick(2);
		chk(16'(rx_irq), 16'h0001);
		wr(16'h00f0);
		chk(16'(rx_irq), 16'h0001);
		for (int f = 24; f < 40; f += 4)
			frm(f, 4);
		chk(scr_rdata, 16'h00fa);
		chk(16'(rx_error_irq), 16'h0000);
		wr(16'h00f5);
		chk(scr_rdata, 16'h00fa);
		rx_error_irq_clear = 1'b1;
		tick(1);
		rx_error_irq_clear = 1'b0;
		tick(2);
		chk(scr_rdata, 16'h00f2);
		rx_error_irq_enable = 1'b1;
		frm(40, 4);
		chk(scr_rdata, 16'h00fa);
		chk(16'(rx_error_irq), 16'h0001);
		chk(16'({dma_full, dma_req}), 16'h0000);
		for (int k = 20; k < 38; k++)
			rd(k);
		tick(2);
		chk(scr_rdata, 16'h00fd);
		chk(16'(rx_irq), 16'h0000);
	endtask

	task automatic t_dma;
		rx_master_dma_field = 4'h3;
		frame_slots_m1 = 2'h1;
		wr(16'h0310);
		frm(60, 2);
		chk(16'(dma_full), 16'h0001);
		chk(dma_data[0], w(60));
		chk(16'(dma_req), 16'h0001);
		chk(16'(rx_data_valid), 16'h0000);
		rx_master_dma_field = 4'h2;
		tick(2);
		chk(16'(dma_req), 16'h0000);
		dma_rd = 4'h1;
		tick(1);
		dma_rd = 4'h0;
		tick(2);
		chk(16'(dma_full), 16'h0000);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end

	// Second reset at the end of the run must clear the sticky flags and DMA state
	initial begin
		t_reset();
		t_tx();
		t_slots();
		t_fill();
		t_dma();
		t_reset();
		stop_test();
	end
endmodule

`default_nettype wire
